// ### dual_tone_melody_control.sv
// module: control logic of the dual tone and melody generator
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module dual_tone_melody_control
(
    input  wire logic                      clock,          // 250 MHz system clock
    input  wire logic                      srst,           // synchronous reset, high
    input  wire logic                      psel,           // apb select
    input  wire logic                      penable,        // apb access phase
    input  wire logic                      pwrite,         // apb write
    input  wire logic [31:0]               paddr,          // apb byte address
    input  wire logic [31:0]               pwdata,         // apb write data
    output logic      [31:0]               prdata,         // apb read data
    output logic                           pready,         // apb ready
    output logic                           pslverr,        // apb error
    output tone_ctrl_pkg::tone_samples_t   samples,        // ladder samples and activity
    output logic                           sine_select,    // low masks five lower bits
    output logic                           filter_power,   // filter current sources on
    output logic                           filtered_tone_pin_out, // open-collector level
    output logic                           filtered_tone_pin_oe,  // tone pin driven
    output logic                           pacifier_pin    // pacifier tone output
);
    import tone_ctrl_pkg::*;

    // ========================================
    // bus slave
    logic [7:0] tone_mode_enable_ctrl_reg;
    logic [4:0] row_freq_code_reg;
    logic [4:0] column_freq_code_reg;
    logic       access;
    logic       hit;
    tone_ctrl_t ctrl;

    assign access  = psel && penable;
    assign hit     = (paddr == ROW_FREQ_ADDR) || (paddr == COL_FREQ_ADDR)
                  || (paddr == TONE_CTRL_ADDR);
    assign pready  = 1'b1;
    assign pslverr = access && !hit;
    assign ctrl    = tone_mode_enable_ctrl_reg[7:4];

    always_ff @(posedge clock) begin
        if (srst) begin
            tone_mode_enable_ctrl_reg <= TONE_CTRL_RESET;
            row_freq_code_reg         <= FREQ_RESET;
            column_freq_code_reg      <= FREQ_RESET;
        end else if (access && pwrite) begin
            if (paddr == TONE_CTRL_ADDR) begin
                tone_mode_enable_ctrl_reg <= pwdata[7:0] & TONE_CTRL_WMASK;
            end
            if (paddr == ROW_FREQ_ADDR) begin
                row_freq_code_reg <= pwdata[4:0];
            end
            if (paddr == COL_FREQ_ADDR) begin
                column_freq_code_reg <= pwdata[4:0];
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == TONE_CTRL_ADDR) begin
            prdata = {24'h00_0000, tone_mode_enable_ctrl_reg};
        end else if (paddr == ROW_FREQ_ADDR) begin
            prdata = {27'h000_0000, row_freq_code_reg};
        end else if (paddr == COL_FREQ_ADDR) begin
            prdata = {27'h000_0000, column_freq_code_reg};
        end
    end

    // ========================================
    // code legality
    function automatic logic code_legal(input logic [4:0] code, input logic is_row);
        logic row_dial;
        logic col_dial;
        row_dial = (code >= ROW_DIAL_FIRST) && (code <= ROW_DIAL_LAST);
        col_dial = (code >= COL_DIAL_FIRST) && (code <= COL_DIAL_LAST);
        code_legal = is_row ? !col_dial : !row_dial;
    endfunction

    // divider period from code; exact table values live outside this block
    function automatic logic [7:0] div_period(input logic [4:0] code);
        div_period = DIV_BASE - {3'b000, code};
    endfunction

    // 28-step staircase sine, index 0 is the dc level
    function automatic logic [5:0] sine_sample(input logic [4:0] idx);
        logic [4:0] q;
        logic [5:0] mag;
        q   = (idx < 5'd14) ? idx : idx - 5'd14;
        mag = (q < 5'd8) ? {q[2:0], 3'b000} : {(3'd6 - q[2:0]), 3'b000};
        sine_sample = (idx < 5'd14) ? SAMPLE_DC + {1'b0, mag[5:1]}
                                    : SAMPLE_DC - {1'b0, mag[5:1]};
    endfunction

    // ========================================
    // path run conditions
    logic       both_off;
    logic       pacifier_mode;
    logic       row_legal;
    logic       col_legal;
    logic [1:0] path_run;
    logic [1:0] path_en;
    logic [1:0] path_legal;
    logic [4:0] path_code [2];

    assign both_off      = !ctrl.row_path_enable && !ctrl.column_path_enable;
    assign pacifier_mode = ctrl.mode[1];
    assign row_legal     = code_legal(row_freq_code_reg, 1'b1);
    assign col_legal     = code_legal(column_freq_code_reg, 1'b0);
    assign path_en       = {ctrl.column_path_enable, ctrl.row_path_enable};
    assign path_legal    = {col_legal, row_legal};
    assign path_code[0]  = row_freq_code_reg;
    assign path_code[1]  = column_freq_code_reg;
    // row path also feeds the pacifier, so it runs in pacifier modes too;
    // column path idles in pacifier-only mode so only one tone exists there
    assign path_run      = path_en & path_legal
                         & {(ctrl.mode != MODE_PACIFIER), 1'b1};

    // ========================================
    // per-path divider and scanner
    logic [7:0] div_count_reg [2];
    logic [4:0] scan_index_reg [2];

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_path
            always_ff @(posedge clock) begin
                if (srst || both_off || !path_run[p]) begin
                    div_count_reg[p]  <= 8'h00;
                    scan_index_reg[p] <= SCAN_DC_INDEX;
                end else if (div_count_reg[p] >= div_period(path_code[p])) begin
                    div_count_reg[p]  <= 8'h00;
                    scan_index_reg[p] <= (scan_index_reg[p] == SCAN_STEPS - 5'd1)
                                       ? SCAN_DC_INDEX : scan_index_reg[p] + 5'd1;
                end else begin
                    div_count_reg[p] <= div_count_reg[p] + 8'h01;
                end
            end
        end
    endgenerate

    // ========================================
    // pins and filter
    logic [5:0] row_smp;
    logic [5:0] col_smp;
    logic       tone_path_ok;
    logic       filter_next;
    logic       oe_next;
    logic       pac_next;

    assign row_smp = sine_sample(scan_index_reg[0]);
    assign col_smp = sine_sample(scan_index_reg[1]);
    assign tone_path_ok = row_legal && col_legal;

    always_comb begin
        filter_next = 1'b0;
        oe_next     = 1'b0;
        pac_next    = 1'b1;
        unique case (ctrl.mode)
            MODE_SINE, MODE_SQUARE: begin
                filter_next = !both_off && tone_path_ok;
                oe_next     = filter_next;
                pac_next    = !both_off;
            end
            MODE_PACIFIER: begin
                pac_next = both_off ? 1'b0
                         : (!row_legal || !path_run[0] || row_smp[5]);
            end
            MODE_SQUARE_PACIFIER: begin
                filter_next = path_run[1];
                oe_next     = path_run[1];
                pac_next    = both_off ? 1'b0
                            : (!row_legal || !path_run[0] || row_smp[5]);
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            filter_power          <= 1'b0;
            filtered_tone_pin_oe  <= 1'b0;
            filtered_tone_pin_out <= 1'b0;
            pacifier_pin          <= 1'b0;
            sine_select           <= 1'b1;
            samples               <= '0;
        end else begin
            filter_power          <= filter_next;
            filtered_tone_pin_oe  <= oe_next;
            filtered_tone_pin_out <= 1'b0;   // open collector pulls low when driven
            pacifier_pin          <= pac_next;
            sine_select           <= (ctrl.mode == MODE_SINE);
            samples.row_sample    <= pacifier_mode ? SAMPLE_DC : row_smp;
            samples.column_sample <= col_smp;
            samples.row_active    <= path_run[0] && !pacifier_mode;
            samples.column_active <= path_run[1];
        end
    end

    // ========================================
    // checks
    a_reset_ctrl_zero: assert property (@(posedge clock)
        srst |=> tone_mode_enable_ctrl_reg == TONE_CTRL_RESET)
        else $error("control register not cleared by reset");
    a_low_bits_zero: assert property (@(posedge clock) disable iff (srst)
        tone_mode_enable_ctrl_reg[3:0] == 4'h0)
        else $error("unused control bits not zero");
    a_off_counters: assert property (@(posedge clock) disable iff (srst)
        both_off |=> scan_index_reg[0] == SCAN_DC_INDEX && scan_index_reg[1] == SCAN_DC_INDEX
                  && div_count_reg[0] == 8'h00 && div_count_reg[1] == 8'h00)
        else $error("counters run while disabled");
    a_off_pins: assert property (@(posedge clock) disable iff (srst)
        both_off |=> !filtered_tone_pin_oe && !pacifier_pin && !filter_power)
        else $error("disabled pin levels wrong");
    a_pacifier_filter: assert property (@(posedge clock) disable iff (srst)
        ctrl.mode == MODE_PACIFIER
        |=> !filter_power && !filtered_tone_pin_oe && !samples.column_active)
        else $error("filter on in pacifier mode");
    a_illegal_code: assert property (@(posedge clock) disable iff (srst)
        ((ctrl.mode == MODE_SINE || ctrl.mode == MODE_SQUARE) && !tone_path_ok && !both_off)
        |=> !filtered_tone_pin_oe && pacifier_pin)
        else $error("illegal code output wrong");
    a_scan_wrap: assert property (@(posedge clock) disable iff (srst)
        scan_index_reg[1] < SCAN_STEPS)
        else $error("scanner out of range");
    a_run_filter: assert property (@(posedge clock) disable iff (srst)
        (ctrl.mode == MODE_SINE && path_run[0] && tone_path_ok) |=> filter_power)
        else $error("filter off with enabled path");
endmodule

// ### tone_ctrl_pkg.sv
// package: register map, field layout and control types for the tone control block
package tone_ctrl_pkg;
    // ========================================
    // register map
    localparam logic [31:0] ROW_FREQ_OFFSET   = 32'h0000_0013;
    localparam logic [31:0] COL_FREQ_OFFSET   = 32'h0000_0014;
    localparam logic [31:0] TONE_CTRL_OFFSET  = 32'h0000_0015;
    localparam logic [31:0] ROW_FREQ_ADDR     = 32'h0000_004C;
    localparam logic [31:0] COL_FREQ_ADDR     = 32'h0000_0050;
    localparam logic [31:0] TONE_CTRL_ADDR    = 32'h0000_0054;
    localparam logic [7:0]  TONE_CTRL_RESET   = 8'h00;
    localparam logic [4:0]  FREQ_RESET        = 5'h00;
    localparam logic [7:0]  TONE_CTRL_WMASK   = 8'hF0;
    // ========================================
    // field positions
    localparam int MODE_HI_BIT  = 7;
    localparam int MODE_LO_BIT  = 6;
    localparam int ROW_EN_BIT   = 5;
    localparam int COL_EN_BIT   = 4;
    // ========================================
    // legal code ranges
    localparam logic [4:0] ROW_DIAL_FIRST = 5'h00;
    localparam logic [4:0] ROW_DIAL_LAST  = 5'h03;
    localparam logic [4:0] COL_DIAL_FIRST = 5'h10;
    localparam logic [4:0] COL_DIAL_LAST  = 5'h13;
    // ========================================
    // sine table
    localparam logic [4:0] SCAN_STEPS     = 5'd28;
    localparam logic [4:0] SCAN_DC_INDEX  = 5'd0;
    localparam logic [5:0] SAMPLE_DC      = 6'h20;
    localparam logic [7:0] DIV_BASE       = 8'd40;

    typedef enum logic [1:0] {
        MODE_SINE,
        MODE_SQUARE,
        MODE_PACIFIER,
        MODE_SQUARE_PACIFIER
    } tone_mode_t;

    typedef struct packed {
        tone_mode_t mode;
        logic       row_path_enable;
        logic       column_path_enable;
    } tone_ctrl_t;

    typedef struct packed {
        logic [5:0] row_sample;
        logic [5:0] column_sample;
        logic       row_active;
        logic       column_active;
    } tone_samples_t;
endpackage

// ### dual_tone_melody_control_tb.sv
// testbench: apb register access and pin behaviour of the tone control block
`timescale 1ns/1ns
module dual_tone_melody_control_tb;
    import tone_ctrl_pkg::*;
    // ========================================
    // signals
    logic          clock;
    logic          srst;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [31:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    tone_samples_t samples;
    logic          sine_select;
    logic          filter_power;
    logic          tone_out;
    logic          tone_oe;
    logic          pacifier_pin;
    logic [31:0]   rd;
    logic          err;
    logic          seen_low;
    int            miscompares = 0;
    int            n_compared  = 0;

    dual_tone_melody_control dut (
        .clock                 (clock),
        .srst                  (srst),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .samples               (samples),
        .sine_select           (sine_select),
        .filter_power          (filter_power),
        .filtered_tone_pin_out (tone_out),
        .filtered_tone_pin_oe  (tone_oe),
        .pacifier_pin          (pacifier_pin)
    );

    initial clock = 1'b0;
    always #2 clock = ~clock;

    // ========================================
    // tasks
    task automatic end_sim();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // master holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) chk("pready", 32'h0000_0001, 32'h0000_0000);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // write control, then let counters and pins settle
    task automatic ctrl(input logic [1:0] m, input logic r, input logic c);
        apb(1'b1, TONE_CTRL_ADDR, {24'h0000_00, m, r, c, 4'h0});
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic pins(input logic oe, input logic pac, input logic filt);
        chk("tone_oe", {31'h0, oe}, {31'h0, tone_oe});
        chk("pacifier_pin", {31'h0, pac}, {31'h0, pacifier_pin});
        chk("filter_power", {31'h0, filt}, {31'h0, filter_power});
        chk("tone_out", 32'h0000_0000, {31'h0, tone_out});
    endtask

    // ========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("BAD watchdog expected finish seen hang");
        end_sim();
    end

    // ========================================
    // main sequence
    initial begin
        srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0000_0000; pwdata = 32'h0000_0000;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        pins(1'b0, 1'b0, 1'b0);
        chk("sine_select", 32'h0000_0001, {31'h0, sine_select});
        apb(1'b0, TONE_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl reset", {24'h0, TONE_CTRL_RESET}, rd);
        chk("mapped read err", 32'h0000_0000, {31'h0, err});
        $display("test reset done");

        apb(1'b1, TONE_CTRL_ADDR, 32'h0000_00FF);
        apb(1'b0, TONE_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl all ones", 32'h0000_00F0, rd);
        apb(1'b1, TONE_CTRL_ADDR, 32'h0000_000F);
        apb(1'b0, TONE_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl low bits", 32'h0000_0000, rd);
        apb(1'b1, 32'h0000_0100, 32'h0000_00F0);
        chk("unmapped write err", 32'h0000_0001, {31'h0, err});
        apb(1'b0, 32'h0000_0100, 32'h0000_0000);
        chk("unmapped read data", 32'h0000_0000, rd);
        apb(1'b0, TONE_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl after unmapped", 32'h0000_0000, rd);
        $display("test register access done");

        apb(1'b1, ROW_FREQ_ADDR, {27'h0, ROW_DIAL_FIRST});
        apb(1'b1, COL_FREQ_ADDR, 32'h0000_00F0);
        apb(1'b0, COL_FREQ_ADDR, 32'h0000_0000);
        chk("col freq", {27'h0, COL_DIAL_FIRST}, rd);
        for (int m = 0; m < 4; m++) begin
            ctrl(m[1:0], 1'b0, 1'b0);
            pins(1'b0, 1'b0, 1'b0);
        end
        $display("test disabled modes done");

        ctrl(2'b00, 1'b1, 1'b1);
        pins(1'b1, 1'b1, 1'b1);
        chk("sine_select", 32'h0000_0001, {31'h0, sine_select});
        chk("dual", 32'h0000_0003, {30'h0, samples.row_active, samples.column_active});
        ctrl(2'b00, 1'b0, 1'b0);
        ctrl(2'b00, 1'b1, 1'b0);
        chk("row start sample", {26'h0, SAMPLE_DC}, {26'h0, samples.row_sample});
        chk("single", 32'h0000_0002, {30'h0, samples.row_active, samples.column_active});
        pins(1'b1, 1'b1, 1'b1);
        $display("test sine done");

        ctrl(2'b01, 1'b0, 1'b1);
        pins(1'b1, 1'b1, 1'b1);
        chk("square select", 32'h0000_0000, {31'h0, sine_select});
        chk("col start sample", {26'h0, SAMPLE_DC}, {26'h0, samples.column_sample});
        $display("test square done");

        apb(1'b1, COL_FREQ_ADDR, {27'h0, ROW_DIAL_LAST});
        ctrl(2'b00, 1'b1, 1'b1);
        chk("illegal oe", 32'h0000_0000, {31'h0, tone_oe});
        chk("illegal pacifier", 32'h0000_0001, {31'h0, pacifier_pin});
        apb(1'b1, COL_FREQ_ADDR, {27'h0, COL_DIAL_LAST});
        $display("test illegal code done");

        ctrl(2'b10, 1'b1, 1'b1);
        chk("pacifier oe", 32'h0000_0000, {31'h0, tone_oe});
        chk("pacifier filter", 32'h0000_0000, {31'h0, filter_power});
        chk("pacifier row", 32'h0000_0000, {31'h0, samples.row_active});
        chk("pacifier col", 32'h0000_0000, {31'h0, samples.column_active});
        seen_low = 1'b0;
        repeat (2 * SCAN_STEPS * (DIV_BASE + 1)) begin
            @(negedge clock);
            if (pacifier_pin === 1'b0) seen_low = 1'b1;
        end
        chk("pacifier toggles", 32'h0000_0001, {31'h0, seen_low});
        ctrl(2'b11, 1'b0, 1'b1);
        chk("both mode oe", 32'h0000_0001, {31'h0, tone_oe});
        chk("both mode col", 32'h0000_0001, {31'h0, samples.column_active});
        $display("test pacifier modes done");

        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        apb(1'b0, TONE_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl mid reset", {24'h0, TONE_CTRL_RESET}, rd);
        @(negedge clock);
        pins(1'b0, 1'b0, 1'b0);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
